// ==== tiio_cfg.svh ====
// Constants for the triggered inventory I/O block
`ifndef TIIO_CFG_SVH
`define TIIO_CFG_SVH
`define TIIO_ADDR_W        4
`define TIIO_OFF_PCW       4'h0
`define TIIO_OFF_PULSE_MS  4'h1
`define TIIO_OFF_STATUS    4'h2
`define TIIO_PCW_ACTIVITY_OUTPUT_ZERO_BIT 9
`define TIIO_PCW_TRIGGER_INPUT_POSITIVE_BIT  13
`define TIIO_PCW_RST       16'h0000
`define TIIO_PULSE_RST     16'h0000
`define TIIO_CLK_MHZ       125
`define TIIO_MS_CYCLES     (`TIIO_CLK_MHZ * 1000)
`define TIIO_INIT_US       10
`define TIIO_INIT_CYCLES   (`TIIO_INIT_US * `TIIO_CLK_MHZ)
`define TIIO_PERIOD_RST    16'h0100
`define TIIO_OFF_PERIOD    4'h3
`endif

// ==== tiio_ms_timer.sv ====
// Millisecond down-counter that restarts on every load
`timescale 1ns/1ps
module tiio_ms_timer #(
    parameter int MS_CYCLES = 125000,
    parameter int MS_W      = 16
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_load,
    input  wire logic [MS_W-1:0] i_ms,
    output logic                 o_active
);
    localparam int TW = $clog2(MS_CYCLES + 1);

    // Elaboration guard: the tick and span counters need at least one bit of work
    if (MS_CYCLES < 1 || MS_W < 1) begin : g_bad_params
        $error("tiio_ms_timer: bad parameters");
    end

    logic [TW-1:0]   tick_r;
    logic [MS_W-1:0] ms_left_r;
    wire             tick_end = (tick_r == TW'(MS_CYCLES - 1));
    wire             ms_last  = (ms_left_r == MS_W'(1));

    // A load always restarts the whole span, so running pulses stretch
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tick_r    <= '0;
            ms_left_r <= '0;
        end else if (i_load) begin
            tick_r    <= '0;
            ms_left_r <= i_ms;
        end else if (ms_left_r != '0) begin
            tick_r    <= tick_end ? '0 : tick_r + TW'(1);
            if (tick_end) ms_left_r <= ms_left_r - MS_W'(1);
        end
    end

    assign o_active = (ms_left_r != '0) && !(ms_last && tick_end);
endmodule // tiio_ms_timer

// ==== tiio_partner.sv ====
// Far side: trigger sensor and inventory engine
`timescale 1ns/1ps
module tiio_partner #(parameter int HOLD = 500) (
    input  wire logic i_clk,
    input  wire logic i_trig,
    input  wire logic i_tag_on,
    input  wire logic i_read_start,
    output logic      o_trig_n,
    output logic      o_read_done = 1'b0,
    output logic      o_tag_valid = 1'b0
);
    int hold_r = 0;
    int wait_r = 0;
    bit slow_r = 0;
    // A request keeps the trigger low for HOLD cycles at least
    assign o_trig_n = hold_r == 0;
    always @(posedge i_clk) hold_r <= i_trig ? HOLD : (hold_r > 0 ? hold_r - 1 : 0);
    // Engine answers fast and slow in turn, so busy spans vary
    always @(posedge i_clk) begin
        o_read_done <= wait_r == 1;
        o_tag_valid <= wait_r == 1 && i_tag_on;
        if (i_read_start) begin
            wait_r <= slow_r ? 40 : 2;
            slow_r <= !slow_r;
        end else if (wait_r > 0) wait_r <= wait_r - 1;
    end
endmodule // tiio_partner

// ==== tiio_pkg.sv ====
// Types for the triggered inventory I/O block
package tiio_pkg;
    typedef enum logic [1:0] {
        TIIO_ST_INIT,
        TIIO_ST_IDLE,
        TIIO_ST_BUSY
    } tiio_state_t;
endpackage

// ==== tiio_props.sv ====
// Port assertions for the triggered inventory I/O block
`timescale 1ns/1ps
`include "tiio_cfg.svh"
module tiio_props #(parameter int MS_CYCLES = 1) (
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    input wire logic [`TIIO_ADDR_W-1:0] i_addr,
    input wire logic [15:0]             i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic [15:0]             o_rdata,
    input wire logic                    i_trigger_input_negative_n,
    input wire logic                    i_read_done,
    input wire logic                    i_tag_valid,
    input wire logic                    o_rf_on,
    input wire logic                    o_read_start,
    input wire logic                    o_activity_output_zero
);
    logic gate_r, puls_r;
    logic [15:0] len_r;
    int since_r;
    // Mirror of enables and length; since_r saturates so idle time never wraps
    always_ff @(posedge i_clk) begin
        gate_r <= i_rst ? 1'b0 : (i_wr && i_addr == 4'h0) ? i_wdata[13] : gate_r;
        puls_r <= i_rst ? 1'b0 : (i_wr && i_addr == 4'h0) ? i_wdata[9] : puls_r;
        len_r <= i_rst ? 16'h0000 : (i_wr && i_addr == 4'h1) ? i_wdata : len_r;
        since_r <= (i_rst || (i_tag_valid && puls_r)) ? 0 : since_r + (since_r < 99999);
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    start_pulse_a: assert property (o_read_start |=> !o_read_start)
        else $error("read start too long");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data without read");
    init_first_a: assert property (!o_rf_on |-> !o_read_start)
        else $error("read before rf on");
    rf_hold_a: assert property (o_rf_on |=> o_rf_on)
        else $error("rf dropped");
    gate_block_a: assert property (gate_r && $past(gate_r) && $past(i_trigger_input_negative_n)
        && $past(i_trigger_input_negative_n, 2) |-> !o_read_start) else $error("ungated read");
    hit_pulse_a: assert property (i_tag_valid && puls_r && len_r != 0 |-> ##2 o_activity_output_zero)
        else $error("no pulse on hit");
    pulse_hold_a: assert property (since_r > 2 && since_r < int'(len_r) * MS_CYCLES - 2
        |-> o_activity_output_zero) else $error("pulse ended early");
    pulse_drop_a: assert property (since_r > len_r * MS_CYCLES + 3 |-> !o_activity_output_zero)
        else $error("pulse too long");
endmodule // tiio_props
bind triggered_inventory_io tiio_props #(.MS_CYCLES(MS_CYCLES)) u_props (.*);

// ==== triggered_inventory_io.sv ====
// Trigger gating of inventory reads and the retriggerable activity pulse
//
// Contract
// - Gated: keep reading while trigger asserted
// - Tag singulated: activity output high programmed ms
// - Each tag hit restarts the pulse count
// - Config word 0x2200 enables both functions
// - Two independent enables: gating, pulsing
// - After init, RF on, reads at rate
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tiio_cfg.svh"
module triggered_inventory_io #(
    parameter int INIT_CYCLES = `TIIO_INIT_CYCLES,
    parameter int MS_CYCLES   = `TIIO_MS_CYCLES
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic [`TIIO_ADDR_W-1:0] i_addr,
    input  wire logic [15:0]              i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic [15:0]                   o_rdata,
    input  wire logic                     i_trigger_input_negative_n,
    input  wire logic                     i_read_done,
    input  wire logic                     i_tag_valid,
    output logic                          o_rf_on,
    output logic                          o_read_start,
    output logic                          o_activity_output_zero
);
    // Elaboration guard: a zero count would stall init or the pulse timer
    if (INIT_CYCLES < 1 || MS_CYCLES < 1) begin : g_bad_params
        $error("triggered_inventory_io: bad parameters");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] protocol_config_word_r;
    logic [15:0] pulse_length_setting_r;
    logic [15:0] read_period_r;
    logic [15:0] rdata_r;

    wire wr_pcw    = i_wr && (i_addr == `TIIO_OFF_PCW);
    wire wr_pulse  = i_wr && (i_addr == `TIIO_OFF_PULSE_MS);
    wire wr_period = i_wr && (i_addr == `TIIO_OFF_PERIOD);

    // Independent enable bits; 0x2200 sets both
    wire gate_en  = protocol_config_word_r[`TIIO_PCW_TRIGGER_INPUT_POSITIVE_BIT];
    wire pulse_en = protocol_config_word_r[`TIIO_PCW_ACTIVITY_OUTPUT_ZERO_BIT];

    // Register writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            protocol_config_word_r <= `TIIO_PCW_RST;
            pulse_length_setting_r <= `TIIO_PULSE_RST;
            read_period_r          <= `TIIO_PERIOD_RST;
        end else begin
            if (wr_pcw) protocol_config_word_r <= i_wdata;
            if (wr_pulse) pulse_length_setting_r <= i_wdata;
            if (wr_period) read_period_r <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    tiio_pkg::tiio_state_t state_r, state_nxt;
    logic [31:0]           cnt_r;
    logic [15:0]           gap_r;

    // Trigger is active low; no debounce, the 50 ms hold is the source's duty
    wire trig_on    = !i_trigger_input_negative_n;
    wire allow_read = !gate_en || trig_on;
    wire init_done  = (cnt_r == 32'(INIT_CYCLES - 1));
    wire gap_done   = (gap_r >= read_period_r);
    wire start      = (state_r == tiio_pkg::TIIO_ST_IDLE) && allow_read && gap_done;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tiio_pkg::TIIO_ST_INIT: if (init_done) state_nxt = tiio_pkg::TIIO_ST_IDLE;
            tiio_pkg::TIIO_ST_IDLE: if (start) state_nxt = tiio_pkg::TIIO_ST_BUSY;
            // A running read completes even if the trigger drops
            tiio_pkg::TIIO_ST_BUSY: if (i_read_done) state_nxt = tiio_pkg::TIIO_ST_IDLE;
            default: state_nxt = tiio_pkg::TIIO_ST_INIT;
        endcase
    end

    // State, init counter and inter-read gap counter
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= tiio_pkg::TIIO_ST_INIT;
            cnt_r   <= '0;
            gap_r   <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == tiio_pkg::TIIO_ST_INIT) cnt_r <= cnt_r + 32'd1;
            if (start) gap_r <= '0;
            else if (state_r == tiio_pkg::TIIO_ST_IDLE && !gap_done) gap_r <= gap_r + 16'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Activity pulse
    wire tag_hit = pulse_en && i_tag_valid;
    wire pulse_active;

    // Each hit reloads the timer, stretching the pulse
    tiio_ms_timer #(
        .MS_CYCLES (MS_CYCLES),
        .MS_W      (16)
    ) u_timer (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_load   (tag_hit),
        .i_ms     (pulse_length_setting_r),
        .o_active (pulse_active)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and registered outputs
    wire [15:0] status = {12'h000, pulse_active, trig_on,
                          state_r == tiio_pkg::TIIO_ST_BUSY,
                          state_r != tiio_pkg::TIIO_ST_INIT};
    wire [15:0] rd_mux = (i_addr == `TIIO_OFF_PCW)      ? protocol_config_word_r :
                         (i_addr == `TIIO_OFF_PULSE_MS) ? pulse_length_setting_r :
                         (i_addr == `TIIO_OFF_STATUS)   ? status :
                         (i_addr == `TIIO_OFF_PERIOD)   ? read_period_r : 16'h0000;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r                <= 16'h0000;
            o_rf_on                <= 1'b0;
            o_read_start           <= 1'b0;
            o_activity_output_zero <= 1'b0;
        end else begin
            rdata_r                <= i_rd ? rd_mux : 16'h0000;
            o_rf_on                <= (state_nxt != tiio_pkg::TIIO_ST_INIT);
            o_read_start           <= start;
            o_activity_output_zero <= pulse_active;
        end
    end
    assign o_rdata = rdata_r;
endmodule // triggered_inventory_io

// ==== triggered_inventory_io_tb.sv ====
// Self-checking bench for the triggered inventory I/O block
`timescale 1ns/1ps
module triggered_inventory_io_tb;
    logic clk = 0, rst = 1, wr = 0, rd = 0, trig = 0, tag_on = 0, rd_p = 0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, len, exp_q[$];
    logic trig_n, done, tag_v, rf_on, start, act;
    int num_errors = 0, total_checks = 0, n_start = 0, n_act = 0;
    initial forever #4 clk = !clk;
    triggered_inventory_io #(.INIT_CYCLES(20), .MS_CYCLES(10)) DUT (.i_clk(clk), .i_rst(rst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_trigger_input_negative_n(trig_n), .i_read_done(done), .i_tag_valid(tag_v),
        .o_rf_on(rf_on), .o_read_start(start), .o_activity_output_zero(act));
    tiio_partner #(.HOLD(500)) u_far (.i_clk(clk), .i_trig(trig), .i_tag_on(tag_on),
        .i_read_start(start), .o_trig_n(trig_n), .o_read_done(done), .o_tag_valid(tag_v));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_r(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_r(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic run(input int n);
        @(negedge clk) {n_start, n_act} = 0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_p <= rd;
    always @(negedge clk) if (rd_p) chk(rdata, exp_q.pop_front());
    always @(posedge clk) {n_start, n_act} <= {n_start + start, n_act + act};
    // Watchdog well beyond the planned sequence
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(1));
        len = $urandom_range(4, 2);
        repeat (4) @(posedge clk);
        rst <= 1'b0; // Reset hold scaled down to four cycles
        rd_r(4'h0, 16'h0000);
        rd_r(4'h2, 16'h0000);
        rd_r(4'h3, 16'h0100);
        rd_r(4'h9, 16'h0000);
        run(300);
        chk(rf_on, 1);
        chk(n_start != 0, 1);
        wr_r(4'h3, 16'h0010);
        wr_r(4'h1, len);
        wr_r(4'h0, 16'h2200);
        rd_r(4'h0, 16'h2200);
        rd_r(4'h1, len);
        tag_on <= 1'b1;
        run(60);
        run(300);
        chk(n_start, 0);
        trig <= 1'b1;
        run(1);
        trig <= 1'b0;
        run(450);
        chk(n_start > 10, 1);
        chk(n_act != 0, 1);
        wr_r(4'h0, 16'h0200);
        run(200);
        chk(n_start != 0, 1);
        wr_r(4'h0, 16'h2000);
        trig <= 1'b1;
        run(60);
        trig <= 1'b0;
        run(300);
        chk(n_act, 0);
        run(4);
        wrap_up();
    end
endmodule // triggered_inventory_io_tb
